/* logic/inac_params.svh */
// constants for the indirect memory access and control register bank
`ifndef INAC_PARAMS_SVH
`define INAC_PARAMS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define INAC_OFS_NULL 6'h00
`define INAC_OFS_WLOC 6'h02
`define INAC_OFS_WUP 6'h04
`define INAC_OFS_WLO 6'h06
`define INAC_OFS_WCTL 6'h08
`define INAC_OFS_RLOC 6'h0a
`define INAC_OFS_RCTL 6'h0c
`define INAC_OFS_RUP 6'h0e
`define INAC_OFS_RLO 6'h10
`define INAC_OFS_CTRL 6'h1e
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define INAC_BIT_START 15
`define INAC_BIT_BUSY 8
`define INAC_BIT_DONE 0
`define INAC_BIT_CLS 10
`define INAC_BIT_CLW 9
`define INAC_BIT_CLE 8
`define INAC_SEL_HI 15
`define INAC_SEL_LO 12
`define INAC_NVM_LAST 8'h1f
`define INAC_SHD_FIRST 8'h40
`define INAC_SHD_LAST 8'h5f
// ------------------------------------------------------------
// action codes and trigger bytes
// ------------------------------------------------------------
`define INAC_ACT_NONE 4'h0
`define INAC_ACT_MLOW 4'h1
`define INAC_ACT_MHIGH 4'h2
`define INAC_ACT_TURNS 4'h4
`define INAC_ACT_RELOAD 4'h5
`define INAC_ACT_NONE2 4'h6
`define INAC_ACT_HRST 4'h7
`define INAC_ACT_FST 4'h9
`define INAC_ACT_LBT 4'ha
`define INAC_ACT_BOTH 4'hb
`define INAC_TRIG_UNLK 8'ha5
`define INAC_TRIG_TURNS 8'h46
`define INAC_TRIG_TEST 8'hb9
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define INAC_CLK_MHZ 125
`define INAC_NVM_WR_US 24000
`define INAC_NVM_RD_US 2
`define INAC_NVM_WR_CYC (`INAC_NVM_WR_US * `INAC_CLK_MHZ)
`define INAC_NVM_RD_CYC (`INAC_NVM_RD_US * `INAC_CLK_MHZ)
`define INAC_SHD_CYC 1
// cycles before the two-flop busy level can be trusted after a trigger
`define INAC_ACT_SETTLE 3'h4
`endif

/* logic/inac_pkg.sv */
// types for the indirect memory access and control register bank
`default_nettype none
package inac_pkg;
  typedef enum logic [1:0] {
    INAC_IDLE = 2'b00,
    INAC_RUN = 2'b01,
    INAC_END = 2'b11
  } inac_op_t;
endpackage
`default_nettype wire

/* logic/inac_regs.sv */
// register bank with indirect memory access and device control
`include "inac_params.svh"
`timescale 1ns/1ps
`default_nettype none
module inac_regs
  import inac_pkg::*;
#(
  parameter int WR_CYC = `INAC_NVM_WR_CYC,
  parameter int RD_CYC = `INAC_NVM_RD_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic unlocked,
  output logic mem_wr_req,
  output logic [7:0] mem_wr_loc,
  output logic [31:0] mem_wr_word,
  output logic mem_rd_req,
  output logic [7:0] mem_rd_loc,
  input wire logic [31:0] mem_rd_word,
  output logic act_mlow,
  output logic act_mhigh,
  output logic act_turns_rst,
  output logic act_reload,
  output logic act_hard_rst,
  output logic act_fst,
  output logic act_lbt,
  input wire logic act_busy,
  output logic act_done_flag,
  input wire logic boot_done_evt,
  output logic boot_done_flag,
  output logic warn_clr,
  output logic err_clr
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // true when a location falls in the nonvolatile range (at or below INAC_NVM_LAST)
  function automatic logic inac_is_nvm(input logic [7:0] loc);
    inac_is_nvm = (loc <= `INAC_NVM_LAST);
  endfunction

  function automatic logic inac_hit(input logic [5:0] a, input logic [5:0] ofs);
    inac_hit = (a == ofs);
  endfunction

  logic [7:0] wr_loc;
  logic [15:0] wr_word_upper;
  logic [15:0] wr_word_lower;
  logic [7:0] rd_loc;
  logic [15:0] rd_word_upper;
  logic [15:0] rd_word_lower;
  logic [3:0] act_sel;
  inac_op_t wr_state;
  inac_op_t rd_state;
  logic [31:0] wr_cnt;
  logic [31:0] rd_cnt;
  logic wr_done;
  logic rd_done;
  logic act_run;
  logic act_sync1;
  logic act_sync2;
  logic boot_sync1;
  logic boot_sync2;
  logic boot_prev;
  logic do_wr_start;
  logic do_rd_start;
  logic do_ctrl;
  logic do_trig;
  logic trig_ok;
  logic [2:0] act_wait;
  logic act_end;

  assign do_ctrl = reg_wr && inac_hit(reg_addr, `INAC_OFS_CTRL);
  // start is only accepted while idle
  assign do_wr_start = reg_wr && inac_hit(reg_addr, `INAC_OFS_WCTL) &&
    reg_wdata[`INAC_BIT_START] && (wr_state == INAC_IDLE);
  assign do_rd_start = reg_wr && inac_hit(reg_addr, `INAC_OFS_RCTL) &&
    reg_wdata[`INAC_BIT_START] && (rd_state == INAC_IDLE);

  // ------------------------------------------------------------
  // address and data holding registers
  // ------------------------------------------------------------
  // location and data words written by the host
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_loc <= 8'h00;
      wr_word_upper <= 16'h0000;
      wr_word_lower <= 16'h0000;
      rd_loc <= 8'h00;
    end else if (reg_wr) begin
      if (inac_hit(reg_addr, `INAC_OFS_WLOC)) begin
        wr_loc <= reg_wdata[7:0];
      end
      if (inac_hit(reg_addr, `INAC_OFS_WUP)) begin
        wr_word_upper <= reg_wdata;
      end
      if (inac_hit(reg_addr, `INAC_OFS_WLO)) begin
        wr_word_lower <= reg_wdata;
      end
      if (inac_hit(reg_addr, `INAC_OFS_RLOC)) begin
        rd_loc <= reg_wdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // indirect write engine
  // ------------------------------------------------------------
  // nonvolatile write waits the long programming time, shadow one cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_state <= INAC_IDLE;
      wr_cnt <= 32'h0000_0000;
      wr_done <= 1'b0;
      mem_wr_req <= 1'b0;
      mem_wr_loc <= 8'h00;
      mem_wr_word <= 32'h0000_0000;
    end else begin
      mem_wr_req <= 1'b0;
      case (wr_state)
        INAC_IDLE: begin
          if (do_wr_start) begin
            wr_state <= INAC_RUN;
            wr_done <= 1'b0;
            mem_wr_req <= 1'b1;
            mem_wr_loc <= wr_loc;
            mem_wr_word <= {wr_word_upper, wr_word_lower};
            wr_cnt <= inac_is_nvm(wr_loc) ? 32'(WR_CYC) : 32'(`INAC_SHD_CYC);
          end
        end
        INAC_RUN: begin
          if (wr_cnt <= 32'h0000_0001) begin
            wr_state <= INAC_END;
          end else begin
            wr_cnt <= wr_cnt - 32'h0000_0001;
          end
        end
        INAC_END: begin
          wr_state <= INAC_IDLE;
          wr_done <= 1'b1;
        end
        default: wr_state <= INAC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // indirect read engine
  // ------------------------------------------------------------
  // result is captured at completion and held until the next read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_state <= INAC_IDLE;
      rd_cnt <= 32'h0000_0000;
      rd_done <= 1'b0;
      mem_rd_req <= 1'b0;
      mem_rd_loc <= 8'h00;
      rd_word_upper <= 16'h0000;
      rd_word_lower <= 16'h0000;
    end else begin
      mem_rd_req <= 1'b0;
      case (rd_state)
        INAC_IDLE: begin
          if (do_rd_start) begin
            rd_state <= INAC_RUN;
            rd_done <= 1'b0;
            mem_rd_req <= 1'b1;
            mem_rd_loc <= rd_loc;
            rd_cnt <= inac_is_nvm(rd_loc) ? 32'(RD_CYC) : 32'(`INAC_SHD_CYC);
          end
        end
        INAC_RUN: begin
          if (rd_cnt <= 32'h0000_0001) begin
            rd_state <= INAC_END;
          end else begin
            rd_cnt <= rd_cnt - 32'h0000_0001;
          end
        end
        INAC_END: begin
          rd_state <= INAC_IDLE;
          rd_done <= 1'b1;
          rd_word_upper <= mem_rd_word[31:16];
          rd_word_lower <= mem_rd_word[15:0];
        end
        default: rd_state <= INAC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // special actions
  // ------------------------------------------------------------
  // external busy and boot event come from outside this clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_sync1 <= 1'b0;
      act_sync2 <= 1'b0;
      boot_sync1 <= 1'b0;
      boot_sync2 <= 1'b0;
      boot_prev <= 1'b0;
    end else begin
      act_sync1 <= act_busy;
      act_sync2 <= act_sync1;
      boot_sync1 <= boot_done_evt;
      boot_sync2 <= boot_sync1;
      boot_prev <= boot_sync2;
    end
  end

  // trigger byte must match the selected code; unlock where needed
  always_comb begin
    trig_ok = 1'b0;
    case (act_sel)
      `INAC_ACT_MLOW, `INAC_ACT_MHIGH, `INAC_ACT_RELOAD, `INAC_ACT_HRST:
        trig_ok = unlocked && (reg_wdata[7:0] == `INAC_TRIG_UNLK);
      `INAC_ACT_TURNS: trig_ok = (reg_wdata[7:0] == `INAC_TRIG_TURNS);
      `INAC_ACT_FST, `INAC_ACT_LBT, `INAC_ACT_BOTH:
        trig_ok = (reg_wdata[7:0] == `INAC_TRIG_TEST);
      default: trig_ok = 1'b0;
    endcase
  end
  // trigger uses the code already stored; select first, then trigger
  assign do_trig = do_ctrl && !act_run && trig_ok;
  // completion only once the settle count is over and synced busy is low
  assign act_end = act_run && (act_wait == 3'h0) && !act_sync2;

  // hold off completion: the synced busy level lags the launch pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_wait <= 3'h0;
    end else if (do_trig) begin
      act_wait <= `INAC_ACT_SETTLE;
    end else if (act_wait != 3'h0) begin
      act_wait <= act_wait - 3'h1;
    end
  end

  // action select, pulses and completion
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_sel <= `INAC_ACT_NONE;
      act_run <= 1'b0;
      act_mlow <= 1'b0;
      act_mhigh <= 1'b0;
      act_turns_rst <= 1'b0;
      act_reload <= 1'b0;
      act_hard_rst <= 1'b0;
      act_fst <= 1'b0;
      act_lbt <= 1'b0;
    end else begin
      act_turns_rst <= 1'b0;
      act_reload <= 1'b0;
      act_hard_rst <= 1'b0;
      act_fst <= 1'b0;
      act_lbt <= 1'b0;
      if (do_trig) begin
        act_run <= 1'b1;
        act_mlow <= (act_sel == `INAC_ACT_MLOW);
        act_mhigh <= (act_sel == `INAC_ACT_MHIGH);
        act_turns_rst <= (act_sel == `INAC_ACT_TURNS);
        act_reload <= (act_sel == `INAC_ACT_RELOAD);
        act_hard_rst <= (act_sel == `INAC_ACT_HRST);
        act_fst <= (act_sel == `INAC_ACT_FST) || (act_sel == `INAC_ACT_BOTH);
        act_lbt <= (act_sel == `INAC_ACT_LBT) || (act_sel == `INAC_ACT_BOTH);
      end else if (act_end) begin
        // margining stays selected; others return to no action
        act_run <= 1'b0;
        if (act_sel != `INAC_ACT_MLOW && act_sel != `INAC_ACT_MHIGH) begin
          act_sel <= `INAC_ACT_NONE;
        end
      end else if (do_ctrl && !act_run) begin
        act_sel <= reg_wdata[`INAC_SEL_HI:`INAC_SEL_LO];
        if (reg_wdata[`INAC_SEL_HI:`INAC_SEL_LO] != act_sel) begin
          act_mlow <= 1'b0;
          act_mhigh <= 1'b0;
        end
      end
    end
  end

  // done flags: set wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_done_flag <= 1'b0;
      boot_done_flag <= 1'b0;
    end else begin
      if (act_end) begin
        act_done_flag <= 1'b1;
      end else if (do_trig) begin
        act_done_flag <= 1'b0;
      end else if (do_ctrl && reg_wdata[`INAC_BIT_CLS]) begin
        act_done_flag <= 1'b0;
      end
      if (boot_sync2 && !boot_prev) begin
        boot_done_flag <= 1'b1;
      end else if (do_ctrl && reg_wdata[`INAC_BIT_CLS]) begin
        boot_done_flag <= 1'b0;
      end
    end
  end

  // clear pulses toward warning and error registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      warn_clr <= 1'b0;
      err_clr <= 1'b0;
    end else begin
      warn_clr <= do_ctrl && reg_wdata[`INAC_BIT_CLW];
      err_clr <= do_ctrl && reg_wdata[`INAC_BIT_CLE];
    end
  end

  // ------------------------------------------------------------
  // read-back
  // ------------------------------------------------------------
  // registered read data; unmapped and null offsets read zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `INAC_OFS_NULL: reg_rdata <= 16'h0000;
        `INAC_OFS_WLOC: reg_rdata <= {8'h00, wr_loc};
        `INAC_OFS_WUP: reg_rdata <= wr_word_upper;
        `INAC_OFS_WLO: reg_rdata <= wr_word_lower;
        `INAC_OFS_WCTL: reg_rdata <= {7'h00, wr_state != INAC_IDLE, 7'h00, wr_done};
        `INAC_OFS_RLOC: reg_rdata <= {8'h00, rd_loc};
        `INAC_OFS_RCTL: reg_rdata <= {7'h00, rd_state != INAC_IDLE, 7'h00, rd_done};
        `INAC_OFS_RUP: reg_rdata <= rd_word_upper;
        `INAC_OFS_RLO: reg_rdata <= rd_word_lower;
        `INAC_OFS_CTRL: reg_rdata <= {act_sel, 12'h000};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // inac_regs
`default_nettype wire

/* dv/inac_regs_asserts.sv */
// port checks for the register bank
`timescale 1ns/1ps
`default_nettype none
module inac_regs_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic unlocked,
  input wire logic mem_wr_req,
  input wire logic mem_rd_req,
  input wire logic act_turns_rst,
  input wire logic act_reload,
  input wire logic act_hard_rst,
  input wire logic act_fst,
  input wire logic act_lbt,
  input wire logic act_done_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // read side and launches
  // ------------------------------------------------------------
  chk_null_reads_zero: assert property (reg_rd && reg_addr == 6'h00 |=> reg_rdata == 16'h0000)
    else $error("null register not zero");
  chk_start_bits_zero: assert property (reg_rd && (reg_addr == 6'h08 || reg_addr == 6'h0c)
    |=> reg_rdata[15:9] == 7'h00 && reg_rdata[7:1] == 7'h00) else $error("start bit reads one");
  chk_ctrl_wo_zero: assert property (reg_rd && reg_addr == 6'h1e |=> reg_rdata[9:0] == 10'h000)
    else $error("write-only control bits read one");
  chk_wr_launch: assert property (mem_wr_req |-> $past(reg_wr && reg_addr == 6'h08 && reg_wdata[15]))
    else $error("write launched without start");
  chk_rd_launch: assert property (mem_rd_req |-> $past(reg_wr && reg_addr == 6'h0c && reg_wdata[15]))
    else $error("read launched without start");
  chk_wr_no_restart: assert property (mem_wr_req |=> !mem_wr_req [*2])
    else $error("write relaunched while busy");
  // ------------------------------------------------------------
  // action triggers
  // ------------------------------------------------------------
  chk_turns_trig: assert property (act_turns_rst |-> $past(reg_wr && reg_addr == 6'h1e && reg_wdata[7:0] == 8'h46))
    else $error("turns reset without its trigger");
  chk_test_trig: assert property (act_fst || act_lbt
    |-> $past(reg_wr && reg_addr == 6'h1e && reg_wdata[7:0] == 8'hb9)) else $error("self-test without trigger");
  chk_unlock_gate: assert property (act_reload || act_hard_rst
    |-> $past(unlocked && reg_wr && reg_wdata[7:0] == 8'ha5)) else $error("locked action ran");
  chk_done_cleared: assert property (act_turns_rst || act_fst |=> !act_done_flag)
    else $error("action done not cleared");
endmodule // inac_regs_asserts
bind inac_regs inac_regs_asserts u_chk (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .unlocked(unlocked),
  .mem_wr_req(mem_wr_req), .mem_rd_req(mem_rd_req), .act_turns_rst(act_turns_rst), .act_reload(act_reload),
  .act_hard_rst(act_hard_rst), .act_fst(act_fst), .act_lbt(act_lbt), .act_done_flag(act_done_flag));
`default_nettype wire

/* dv/inac_far_model.sv */
// far-side model: indirect memory and action engine
`timescale 1ns/1ps
`default_nettype none
module inac_far_model (
  input wire logic core_clk,
  input wire logic mem_wr_req,
  input wire logic [7:0] mem_wr_loc,
  input wire logic [31:0] mem_wr_word,
  input wire logic [7:0] mem_rd_loc,
  input wire logic act_pulse,
  output logic [31:0] mem_rd_word,
  output logic act_busy
);
  logic [31:0] mem [256];
  int wr_count = 0;
  int busy_left = 0;
  // seed cells with a location pattern
  initial foreach (mem[i]) mem[i] = 32'h5a5a_0000 | 32'(i);
  // store each launched write whole
  always @(posedge core_clk) begin
    if (mem_wr_req) begin
      mem[mem_wr_loc] <= mem_wr_word;
      wr_count <= wr_count + 1;
    end
  end
  // an action stays busy for six cycles
  always @(posedge core_clk) begin
    if (act_pulse) busy_left <= 6;
    else if (busy_left > 0) busy_left <= busy_left - 1;
  end
  assign act_busy = busy_left > 0;
  assign mem_rd_word = mem[mem_rd_loc];
endmodule // inac_far_model
`default_nettype wire

/* dv/inac_regs_tb.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module inac_regs_tb;
  typedef struct {logic [5:0] a; logic [15:0] w; logic [15:0] e;} inac_row_t;
  typedef struct {logic [3:0] c; logic [7:0] t; logic u; logic [8:0] e;} inac_act_t;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, unlocked = 0, boot_done_evt = 0;
  logic [5:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, rd_val;
  logic mem_wr_req, mem_rd_req, act_busy, act_done_flag, boot_done_flag, warn_clr, err_clr;
  logic act_mlow, act_mhigh, act_turns_rst, act_reload, act_hard_rst, act_fst, act_lbt;
  logic [7:0] mem_wr_loc, mem_rd_loc;
  logic [31:0] mem_wr_word, mem_rd_word;
  logic [8:0] seen = 0;
  int num_errors = 0, compares = 0, cycles = 0;
  inac_row_t rows [6] = '{'{6'h00, 16'hffff, 16'h0000}, '{6'h02, 16'hffab, 16'h00ab},
    '{6'h04, 16'h1234, 16'h1234}, '{6'h06, 16'habcd, 16'habcd}, '{6'h0a, 16'hff5f, 16'h005f},
    '{6'h12, 16'hffff, 16'h0000}};
  inac_act_t acts [11] = '{'{4'h1, 8'ha5, 1, 9'h001}, '{4'h2, 8'ha5, 1, 9'h002}, '{4'h4, 8'h46, 0, 9'h004},
    '{4'h5, 8'ha5, 1, 9'h008}, '{4'h7, 8'ha5, 1, 9'h010}, '{4'h9, 8'hb9, 1, 9'h020},
    '{4'ha, 8'hb9, 1, 9'h040}, '{4'hb, 8'hb9, 1, 9'h060}, '{4'h7, 8'ha5, 0, 9'h000},
    '{4'h6, 8'ha5, 1, 9'h000}, '{4'h5, 8'h46, 1, 9'h000}};

  inac_regs #(.WR_CYC(20), .RD_CYC(10)) u_inac_regs (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .unlocked(unlocked),
    .mem_wr_req(mem_wr_req), .mem_wr_loc(mem_wr_loc), .mem_wr_word(mem_wr_word), .mem_rd_req(mem_rd_req),
    .mem_rd_loc(mem_rd_loc), .mem_rd_word(mem_rd_word), .act_mlow(act_mlow), .act_mhigh(act_mhigh),
    .act_turns_rst(act_turns_rst), .act_reload(act_reload), .act_hard_rst(act_hard_rst), .act_fst(act_fst),
    .act_lbt(act_lbt), .act_busy(act_busy), .act_done_flag(act_done_flag), .boot_done_evt(boot_done_evt),
    .boot_done_flag(boot_done_flag), .warn_clr(warn_clr), .err_clr(err_clr));
  inac_far_model u_inac_far_model (.core_clk(core_clk), .mem_wr_req(mem_wr_req), .mem_wr_loc(mem_wr_loc),
    .mem_wr_word(mem_wr_word), .mem_rd_loc(mem_rd_loc), .mem_rd_word(mem_rd_word), .act_busy(act_busy),
    .act_pulse(act_turns_rst | act_reload | act_hard_rst | act_fst | act_lbt));

  // ------------------------------------------------------------
  // clock, watchdog, pulse capture
  // ------------------------------------------------------------
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
    seen <= seen | {err_clr, warn_clr, act_lbt, act_fst, act_hard_rst, act_reload, act_turns_rst, act_mhigh, act_mlow};
  end
  // ------------------------------------------------------------
  // bus tasks and compare
  // ------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk) #1;
    reg_wr = 0;
    @(posedge core_clk) #1;
  endtask
  task automatic rd(input logic [5:0] a);
    reg_rd = 1;
    reg_addr = a;
    @(posedge core_clk) #1;
    reg_rd = 0;
    @(posedge core_clk) #1;
    rd_val = reg_rdata;
  endtask
  task automatic poll(input logic [5:0] a, input logic [15:0] e);
    rd(a);
    for (int i = 0; i < 60 && rd_val !== e; i++) rd(a);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    #1 nrst = 1;
    repeat (3) @(posedge core_clk) #1;
    boot_done_evt = 1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("reg", rows[i].e, rd_val);
    end
    $display("test regs done");
    wr(6'h02, 16'h0005);
    wr(6'h04, 16'hcafe);
    wr(6'h06, 16'hbeef);
    wr(6'h08, 16'h8000);
    rd(6'h08);
    chk("wr busy", 16'h0100, rd_val);
    wr(6'h08, 16'h8000);
    poll(6'h08, 16'h0001);
    chk("wr done", 16'h0001, rd_val);
    chk("wr count", 1, u_inac_far_model.wr_count);
    chk("cell", 32'hcafebeef, u_inac_far_model.mem[5]);
    $display("test write done");
    wr(6'h0a, 16'h0005);
    wr(6'h0c, 16'h8000);
    rd(6'h0c);
    chk("rd busy", 16'h0100, rd_val);
    poll(6'h0c, 16'h0001);
    chk("rd done", 16'h0001, rd_val);
    rd(6'h0e);
    chk("rd upper", 16'hcafe, rd_val);
    rd(6'h10);
    chk("rd lower", 16'hbeef, rd_val);
    wr(6'h0c, 16'h8000);
    rd(6'h0c);
    chk("rd restart", 16'h0100, rd_val);
    poll(6'h0c, 16'h0001);
    $display("test read done");
    foreach (acts[i]) begin
      unlocked = acts[i].u;
      wr(6'h1e, {acts[i].c, 12'h000});
      repeat (2) @(posedge core_clk) #1;
      seen = 0;
      wr(6'h1e, {acts[i].c, 4'h0, acts[i].t});
      repeat (14) @(posedge core_clk) #1;
      chk("actions", acts[i].e, seen);
      if (acts[i].e[8:2] != 7'h00) chk("act done", 1, act_done_flag);
      rd(6'h1e);
      chk("ctrl", {(acts[i].e[8:2] == 7'h00) ? acts[i].c : 4'h0, 12'h000}, rd_val);
    end
    $display("test actions done");
    chk("boot done", 1, boot_done_flag);
    wr(6'h1e, 16'h0400);
    @(posedge core_clk) #1;
    chk("act cleared", 0, act_done_flag);
    chk("boot cleared", 0, boot_done_flag);
    seen = 0;
    wr(6'h1e, 16'h0200);
    wr(6'h1e, 16'h0100);
    @(posedge core_clk) #1;
    chk("clear pulses", 9'h180, seen);
    $display("test clears done");
    wr(6'h08, 16'h8000);
    nrst = 0;
    @(posedge core_clk) #1;
    chk("reset flag", 0, act_done_flag);
    chk("reset rdata", 16'h0000, reg_rdata);
    nrst = 1;
    @(posedge core_clk) #1;
    rd(6'h08);
    chk("reset busy", 16'h0000, rd_val);
    $display("test reset done");
    summarize();
  end
endmodule // inac_regs_tb
`default_nettype wire
